// ===== rtl/baud_gen_pkg.sv
package baud_gen_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_BAUD_CONTROL      = 8'h00;
    localparam logic [7:0] OFS_RECEIVE_STATUS    = 8'h04;
    localparam logic [7:0] OFS_RATE_DIVISOR_LOW  = 8'h08;
    localparam logic [7:0] OFS_RATE_DIVISOR_HIGH = 8'h0C;
    localparam logic [7:0] OFS_TRANSMIT_STATUS   = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_RECEIVER_IDLE  = 6;
    localparam int BIT_WIDE_DIVISOR   = 3;
    localparam int BIT_PORT_MODE_SYNC = 4;
    localparam int BIT_HIGH_SPEED     = 2;
    localparam int BIT_TSR_EMPTY      = 1;

    // ------------------------------------------------------------
    // Writable masks and values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_BAUD_CONTROL     = 8'h1B;
    localparam logic [7:0] MASK_RECEIVE_STATUS   = 8'hF8;
    localparam logic [7:0] MASK_TRANSMIT_STATUS  = 8'hFD;
    localparam logic [7:0] RST_BAUD_CONTROL      = 8'h00;
    localparam logic [7:0] RST_RECEIVE_STATUS    = 8'h00;
    localparam logic [7:0] RST_RATE_DIVISOR      = 8'h00;
    localparam logic [7:0] RST_TRANSMIT_STATUS   = 8'h00;

    // ------------------------------------------------------------
    // Prescale counts: multiplier minus one
    // ------------------------------------------------------------
    localparam int         PRE_W      = 6;
    localparam logic [5:0] PRE_LIM_64 = 6'h3F;
    localparam logic [5:0] PRE_LIM_16 = 6'h0F;
    localparam logic [5:0] PRE_LIM_4  = 6'h03;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        port_sync;
        logic        wide_divisor_enable;
        logic        high_speed_select;
    } rate_cfg_t;

    typedef struct packed {
        logic [7:0]  baud_control;
        logic [7:0]  receive_status_control;
        logic [7:0]  rate_divisor_low;
        logic [7:0]  rate_divisor_high;
        logic [7:0]  transmit_status_control;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } regs_state_t;

    typedef struct packed {
        logic [5:0]  cnt;
        logic        step;
    } pre_state_t;

endpackage : baud_gen_pkg

// ===== rtl/rate_prescaler.sv
`timescale 1ns/1ns
module rate_prescaler (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           clear,
    input  wire logic [baud_gen_pkg::PRE_W-1:0] limit,
    output logic                                step
);
    import baud_gen_pkg::*;

    pre_state_t s_q;
    pre_state_t s_d;

    // ------------------------------------------------------------
    // Multiplier stage: one step every limit+1 cycles
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (clear) begin
            s_d.cnt  = '0;
            s_d.step = 1'b0;
        end else if (s_q.cnt >= limit) begin
            s_d.cnt  = '0;
            s_d.step = 1'b1;
        end else begin
            s_d.cnt  = s_q.cnt + 6'h01;
            s_d.step = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign step = s_q.step;

    chk_pre_single_step: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.step |=> !s_q.step) else $error("prescale step longer than one cycle");

    chk_pre_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
        clear |=> (s_q.cnt == 6'h00) && !s_q.step) else $error("prescaler not cleared");

endmodule : rate_prescaler

// ===== rtl/rate_timer_counter.sv
`timescale 1ns/1ns
module rate_timer_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clear,
    input  wire logic             step,
    input  wire logic [WIDTH-1:0] limit,
    output logic                  tick,
    output logic [WIDTH-1:0]      value
);
    import baud_gen_pkg::*;

    generate
        if (WIDTH < 8 || WIDTH > 16) begin : g_bad_width
            $error("rate_timer_counter width must be 8 to 16");
        end
    endgenerate

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             tick;
    } cnt_state_t;

    cnt_state_t s_q;
    cnt_state_t s_d;

    // ------------------------------------------------------------
    // Free running count of limit+1 steps, then reload
    // ------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (clear) begin
            s_d.cnt = '0;
        end else if (step) begin
            if (s_q.cnt >= limit) begin
                s_d.cnt  = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick  = s_q.tick;
    assign value = s_q.cnt;

    chk_tick_reloads: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.tick |-> (s_q.cnt == '0)) else $error("timer did not reload on tick");

    chk_tick_needs_step: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.tick |-> $past(step) && !$past(clear)) else $error("tick without a step");

endmodule : rate_timer_counter

// ===== rtl/serial_baud_rate_generator.sv
// Function
// - One dedicated rate timer serves async and sync modes, 8 or 16 bits wide.
// - After reset the timer is 8 bits wide, using the low divisor byte only.
// - With wide divisor enabled the timer uses the full high:low divisor.
// - The timer runs freely; its period comes from the low divisor byte, or the high:low pair when wide.
// - Async multiplier depends on both high speed select and wide divisor enable.
// - Async 8-bit low: 64(n+1); async 16-bit low: 16(n+1); sync: 4(n+1).
// - Sync mode ignores high speed select when choosing the multiplier.
// - A write to either divisor byte clears the timer at once.
// - Wide divisor enable is bit 3 of baud control; 1 means 16 bits.
// - High speed select is bit 2 of transmit status control.
// - Port mode select is bit 4 of transmit status control; 1 is sync.
// - Receiver idle flag reads 0 while receiving, 1 when idle.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ns
module serial_baud_rate_generator #(
    parameter int TIMER_W = 16
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               receiver_idle_flag,
    input  wire logic               tsr_empty,
    output logic                    rate_tick,
    output logic      [TIMER_W-1:0] rate_timer_value
);
    import baud_gen_pkg::*;

    generate
        if (TIMER_W != 16) begin : g_bad_timer
            $error("serial_baud_rate_generator needs a 16-bit rate timer");
        end
    endgenerate

    regs_state_t       s_q;
    regs_state_t       s_d;
    rate_cfg_t         cfg;
    logic              access_done;
    logic              wr_en;
    logic              addr_ok;
    logic [7:0]        rd_byte;
    logic              div_write;
    logic [PRE_W-1:0]  pre_limit;
    logic [15:0]       eff_divisor;
    logic              pre_step;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    always_comb begin
        cfg.port_sync           = s_q.transmit_status_control[BIT_PORT_MODE_SYNC];
        cfg.wide_divisor_enable = s_q.baud_control[BIT_WIDE_DIVISOR];
        cfg.high_speed_select   = s_q.transmit_status_control[BIT_HIGH_SPEED];
    end

    always_comb begin
        if (cfg.port_sync) begin
            pre_limit = PRE_LIM_4;
        end else begin
            unique case ({cfg.wide_divisor_enable, cfg.high_speed_select})
                2'b00: pre_limit = PRE_LIM_64;
                2'b01: pre_limit = PRE_LIM_16;
                2'b10: pre_limit = PRE_LIM_16;
                2'b11: pre_limit = PRE_LIM_4;
            endcase
        end
    end

    always_comb begin
        if (cfg.wide_divisor_enable) begin
            eff_divisor = {s_q.rate_divisor_high, s_q.rate_divisor_low};
        end else begin
            eff_divisor = {8'h00, s_q.rate_divisor_low};
        end
    end

    // ------------------------------------------------------------
    // APB slave: one wait state, answer from flip-flops
    // ------------------------------------------------------------
    assign access_done = psel && penable && s_q.pready;
    assign wr_en       = access_done && pwrite && !s_q.pslverr;
    assign addr_ok     = (paddr == OFS_BAUD_CONTROL) || (paddr == OFS_RECEIVE_STATUS)
                      || (paddr == OFS_RATE_DIVISOR_LOW) || (paddr == OFS_RATE_DIVISOR_HIGH)
                      || (paddr == OFS_TRANSMIT_STATUS);
    assign div_write   = wr_en && ((paddr == OFS_RATE_DIVISOR_LOW) || (paddr == OFS_RATE_DIVISOR_HIGH));

    always_comb begin
        rd_byte = 8'h00;
        if (paddr == OFS_BAUD_CONTROL) begin
            rd_byte                    = s_q.baud_control;
            rd_byte[BIT_RECEIVER_IDLE] = receiver_idle_flag;
        end else if (paddr == OFS_RECEIVE_STATUS) begin
            rd_byte = s_q.receive_status_control;
        end else if (paddr == OFS_RATE_DIVISOR_LOW) begin
            rd_byte = s_q.rate_divisor_low;
        end else if (paddr == OFS_RATE_DIVISOR_HIGH) begin
            rd_byte = s_q.rate_divisor_high;
        end else if (paddr == OFS_TRANSMIT_STATUS) begin
            rd_byte                = s_q.transmit_status_control;
            rd_byte[BIT_TSR_EMPTY] = tsr_empty;
        end
    end

    always_comb begin
        s_d = s_q;
        if (psel && penable && !s_q.pready) begin
            s_d.pready  = 1'b1;
            s_d.pslverr = !addr_ok;
            s_d.prdata  = (pwrite || !addr_ok) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end else begin
            s_d.pready  = 1'b0;
            s_d.pslverr = 1'b0;
        end
        if (wr_en) begin
            if (paddr == OFS_BAUD_CONTROL) begin
                s_d.baud_control = pwdata[7:0] & MASK_BAUD_CONTROL;
            end
            if (paddr == OFS_RECEIVE_STATUS) begin
                s_d.receive_status_control = pwdata[7:0] & MASK_RECEIVE_STATUS;
            end
            if (paddr == OFS_RATE_DIVISOR_LOW) begin
                s_d.rate_divisor_low = pwdata[7:0];
            end
            if (paddr == OFS_RATE_DIVISOR_HIGH) begin
                s_d.rate_divisor_high = pwdata[7:0];
            end
            if (paddr == OFS_TRANSMIT_STATUS) begin
                s_d.transmit_status_control = pwdata[7:0] & MASK_TRANSMIT_STATUS;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.baud_control            <= RST_BAUD_CONTROL;
            s_q.receive_status_control  <= RST_RECEIVE_STATUS;
            s_q.rate_divisor_low        <= RST_RATE_DIVISOR;
            s_q.rate_divisor_high       <= RST_RATE_DIVISOR;
            s_q.transmit_status_control <= RST_TRANSMIT_STATUS;
            s_q.pready                  <= 1'b0;
            s_q.pslverr                 <= 1'b0;
            s_q.prdata                  <= 32'h0000_0000;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata  = s_q.prdata;
    assign pready  = s_q.pready;
    assign pslverr = s_q.pslverr;

    // ------------------------------------------------------------
    // Rate timer: prescaler then divisor count
    // ------------------------------------------------------------
    // The tick is registered behind the prescaler step, so the first tick after a
    // divisor write comes one cycle later than every following period.
    rate_prescaler u_prescaler (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (div_write),
        .limit   (pre_limit),
        .step    (pre_step)
    );

    rate_timer_counter #(
        .WIDTH (TIMER_W)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (div_write),
        .step    (pre_step),
        .limit   (eff_divisor),
        .tick    (rate_tick),
        .value   (rate_timer_value)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Cycles since the last tick; not trusted across a divisor write or mode change
    logic [23:0] per_q;
    logic        per_valid_q;
    logic [5:0]  lim_prev_q;
    logic [15:0] div_prev_q;
    logic        cfg_chg;
    logic [23:0] expected_period;

    assign cfg_chg         = (lim_prev_q != pre_limit) || (div_prev_q != eff_divisor);
    assign expected_period = 24'((32'(eff_divisor) + 32'h1) * (32'(pre_limit) + 32'h1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_q       <= 24'h00_0000;
            per_valid_q <= 1'b0;
            lim_prev_q  <= PRE_LIM_64;
            div_prev_q  <= 16'h0000;
        end else begin
            lim_prev_q <= pre_limit;
            div_prev_q <= eff_divisor;
            per_q      <= (rate_tick || div_write) ? 24'h00_0001 : per_q + 24'h00_0001;
            if (div_write || cfg_chg) begin
                per_valid_q <= 1'b0;
            end else if (rate_tick) begin
                per_valid_q <= 1'b1;
            end
        end
    end

    chk_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
        (rate_tick && per_valid_q && !cfg_chg) |-> (per_q == expected_period))
        else $error("rate tick period wrong");

    chk_narrow_divisor: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.baud_control[BIT_WIDE_DIVISOR] |-> (eff_divisor[15:8] == 8'h00))
        else $error("narrow mode uses high divisor byte");

    chk_wide_divisor: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.baud_control[BIT_WIDE_DIVISOR] |-> (eff_divisor[15:8] == s_q.rate_divisor_high))
        else $error("wide mode ignores high divisor byte");

    chk_sync_ignores_speed: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.transmit_status_control[BIT_PORT_MODE_SYNC] |-> (pre_limit == 6'h03))
        else $error("sync multiplier not four");

    chk_async_low_mult: assert property (@(posedge pclk) disable iff (!presetn)
        (!cfg.port_sync && !cfg.high_speed_select) |-> (pre_limit == (cfg.wide_divisor_enable ? 6'h0F : 6'h3F)))
        else $error("async low speed multiplier wrong");

    chk_async_high_mult: assert property (@(posedge pclk) disable iff (!presetn)
        (!cfg.port_sync && cfg.high_speed_select) |-> (pre_limit == (cfg.wide_divisor_enable ? 6'h03 : 6'h0F)))
        else $error("async high speed multiplier wrong");

    chk_write_clears: assert property (@(posedge pclk) disable iff (!presetn)
        div_write |=> (rate_timer_value == 16'h0000) && !rate_tick)
        else $error("divisor write did not clear timer");

    chk_idle_readback: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !s_q.pready && !pwrite && paddr == OFS_BAUD_CONTROL)
        |=> (prdata[BIT_RECEIVER_IDLE] == $past(receiver_idle_flag)))
        else $error("receiver idle flag misread");

    chk_free_running: assert property (@(posedge pclk) disable iff (!presetn)
        (rate_tick && !div_write) |-> ##[1:1000] (rate_tick || div_write || cfg_chg || per_q > 24'h00_03E7))
        else $error("timer stopped after tick");

    chk_tick_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        rate_tick |=> !rate_tick)
        else $error("rate tick longer than one cycle");

    // ------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------
    chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("pready held longer than one cycle");

    chk_one_wait_state: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !s_q.pready) |=> pready)
        else $error("bus answer not after one wait state");

    chk_no_early_ready: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && penable) |=> !pready)
        else $error("bus answer without an access phase");

    chk_bad_addr_error: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !s_q.pready && !addr_ok) |=> (pslverr && prdata == 32'h0000_0000))
        else $error("unmapped address not refused");

    chk_good_addr_ok: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !s_q.pready && addr_ok) |=> !pslverr)
        else $error("mapped address refused");

    // ------------------------------------------------------------
    // Divisor store checks
    // ------------------------------------------------------------
    chk_low_byte_store: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFS_RATE_DIVISOR_LOW) |=> (s_q.rate_divisor_low == $past(pwdata[7:0])))
        else $error("low divisor byte not stored");

    chk_high_byte_store: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFS_RATE_DIVISOR_HIGH) |=> (s_q.rate_divisor_high == $past(pwdata[7:0])))
        else $error("high divisor byte not stored");

    chk_low_read_back: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !s_q.pready && !pwrite && paddr == OFS_RATE_DIVISOR_LOW)
        |=> (prdata[7:0] == s_q.rate_divisor_low))
        else $error("low divisor byte misread");

    chk_refused_write: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && pslverr) |=> $stable(s_q.rate_divisor_low))
        else $error("refused write changed the divisor");

endmodule : serial_baud_rate_generator

// ===== verification/test_serial_baud_rate_generator.sv
`timescale 1ns/1ns
module test_serial_baud_rate_generator;
    import baud_gen_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        receiver_idle_flag;
    logic        tsr_empty;
    logic        rate_tick;
    logic [15:0] rate_timer_value;
    int          bad_count;
    int          n_checks;

    // Mode bits {sync, wide, high speed} and the tick period they give with high 0x01, low 0x02
    logic [2:0]  cfg_tab [8] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b100, 3'b101, 3'b110, 3'b111};
    int          per_tab [8] = '{192, 48, 4144, 1036, 12, 12, 1036, 1036};

    serial_baud_rate_generator #(.TIMER_W(16)) dut (
        .pclk               (pclk),
        .presetn            (presetn),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .paddr              (paddr),
        .pwdata             (pwdata),
        .prdata             (prdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .receiver_idle_flag (receiver_idle_flag),
        .tsr_empty          (tsr_empty),
        .rate_tick          (rate_tick),
        .rate_timer_value   (rate_timer_value)
    );

    always #20 pclk = ~pclk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                  output logic [31:0] rdata, output logic err);
        int w;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        w = 0;
        do begin
            @(posedge pclk);
            w++;
        end while (pready !== 1'b1);
        check(w, 32'h0000_0002, "bus wait cycles");
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task reg_write(input logic [7:0] addr, input logic [31:0] data, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb_xfer(1'b1, addr, data, rd, err);
        check({31'h0, err}, {31'h0, exp_err}, "write error flag");
    endtask : reg_write

    task reg_read(input logic [7:0] addr, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb_xfer(1'b0, addr, 32'h0, rd, err);
        check({31'h0, err}, {31'h0, exp_err}, "read error flag");
        check(rd, exp, "read data");
    endtask : reg_read

    // Two successive tick intervals, the first counted from the last completed write
    task measure(input int p);
        int c;
        int k;
        @(negedge pclk);
        check({16'h0000, rate_timer_value}, 32'h0000_0000, "timer after write");
        for (k = 0; k < 2; k++) begin
            c = 0;
            do begin
                @(posedge pclk);
                c++;
                @(negedge pclk);
            end while (rate_tick !== 1'b1 && c < 20000);
            // First interval carries the registered tick stage
            check(c, (k == 0) ? p + 1 : p, "tick period");
            check({16'h0000, rate_timer_value}, 32'h0000_0000, "timer at tick");
        end
    endtask : measure

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial begin
        #(60000 * 40);
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        pclk               = 1'b0;
        presetn            = 1'b0;
        psel               = 1'b0;
        penable            = 1'b0;
        pwrite             = 1'b0;
        paddr              = 8'h00;
        pwdata             = 32'h0;
        receiver_idle_flag = 1'b1;
        tsr_empty          = 1'b1;
        bad_count          = 0;
        n_checks           = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;

        // Values after reset
        reg_read(OFS_BAUD_CONTROL, 32'h0000_0040, 1'b0);
        reg_read(OFS_RECEIVE_STATUS, 32'h0000_0000, 1'b0);
        reg_read(OFS_RATE_DIVISOR_LOW, 32'h0000_0000, 1'b0);
        reg_read(OFS_RATE_DIVISOR_HIGH, 32'h0000_0000, 1'b0);
        reg_read(OFS_TRANSMIT_STATUS, 32'h0000_0002, 1'b0);

        // Writable bits and reserved bits
        reg_write(OFS_BAUD_CONTROL, 32'hFFFF_FFFF, 1'b0);
        reg_read(OFS_BAUD_CONTROL, 32'h0000_005B, 1'b0);
        reg_write(OFS_RECEIVE_STATUS, 32'hFFFF_FFFF, 1'b0);
        reg_read(OFS_RECEIVE_STATUS, 32'h0000_00F8, 1'b0);
        reg_write(OFS_TRANSMIT_STATUS, 32'hFFFF_FFFF, 1'b0);
        reg_read(OFS_TRANSMIT_STATUS, 32'h0000_00FF, 1'b0);
        reg_write(OFS_RATE_DIVISOR_LOW, 32'hFFFF_FFA5, 1'b0);
        reg_read(OFS_RATE_DIVISOR_LOW, 32'h0000_00A5, 1'b0);
        reg_write(OFS_RATE_DIVISOR_HIGH, 32'h0000_005A, 1'b0);
        reg_read(OFS_RATE_DIVISOR_HIGH, 32'h0000_005A, 1'b0);

        // Live status inputs
        @(posedge pclk);
        receiver_idle_flag <= 1'b0;
        tsr_empty          <= 1'b0;
        reg_read(OFS_BAUD_CONTROL, 32'h0000_001B, 1'b0);
        reg_read(OFS_TRANSMIT_STATUS, 32'h0000_00FD, 1'b0);
        receiver_idle_flag <= 1'b1;
        reg_read(OFS_BAUD_CONTROL, 32'h0000_005B, 1'b0);

        // Unmapped and misaligned addresses
        reg_read(8'h14, 32'h0000_0000, 1'b1);
        reg_read(8'h01, 32'h0000_0000, 1'b1);
        reg_write(8'h09, 32'h0000_0011, 1'b1);
        reg_read(OFS_RATE_DIVISOR_LOW, 32'h0000_00A5, 1'b0);

        // Every mode combination, high byte set to show where it is ignored
        for (int i = 0; i < 8; i++) begin
            reg_write(OFS_BAUD_CONTROL, {28'h0, cfg_tab[i][1], 3'b000}, 1'b0);
            reg_write(OFS_TRANSMIT_STATUS, {27'h0, cfg_tab[i][2], 1'b0, cfg_tab[i][0], 2'b00}, 1'b0);
            reg_write(OFS_RATE_DIVISOR_HIGH, 32'h0000_0001, 1'b0);
            reg_write(OFS_RATE_DIVISOR_LOW, 32'h0000_0002, 1'b0);
            measure(per_tab[i]);
        end

        // A write to either divisor byte in mid-period restarts the count
        reg_write(OFS_BAUD_CONTROL, 32'h0000_0000, 1'b0);
        reg_write(OFS_TRANSMIT_STATUS, 32'h0000_0000, 1'b0);
        reg_write(OFS_RATE_DIVISOR_LOW, 32'h0000_0002, 1'b0);
        measure(192);
        repeat (100) @(posedge pclk);
        reg_write(OFS_RATE_DIVISOR_HIGH, 32'h0000_0000, 1'b0);
        measure(192);
        repeat (50) @(posedge pclk);
        reg_write(OFS_RATE_DIVISOR_LOW, 32'h0000_0000, 1'b0);
        measure(64);

        report_and_stop();
    end

endmodule : test_serial_baud_rate_generator
